// ===== amt_pkg.sv
package amt_pkg;
  typedef struct packed {
    logic fifo;
    logic lock_loss;
    logic link;
    logic realign;
    logic oscillator;
    logic divider;
  } amt_alarm_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } amt_bus_t;
endpackage

// ===== amt_regs.sv
// Operation
// - Each of the six suppress bits keeps its alarm out of the summary flag.
// - The suppress register resets to all six bits set, upper bits clear.
// - A 16-bit lane fault register sets bit i on lane i FIFO over/underflow.
// - Writing one to a lane fault bit clears it, writing zero keeps it.
// - A lane condition still present at clear sets the bit again at once.
// - All lane fault bits read one after reset until cleared.
// - Each trim register holds an 8-bit sampling code for one core and mode.
// - Trim registers start with factory codes and are readable and writable.
// - Dual mode uses 0x310 for core A and 0x313 for core B.
// - Single mode uses 0x314, 0x315 and 0x31a for the three core/inputs.
// - The summary flag is one when any unsuppressed alarm status bit is set.
// - The FIFO alarm status is set when any lane FIFO over/underflows.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "amt_regs.svh"

module amt_regs #(
  parameter int LANES = 16,
  parameter logic [7:0] TRIM_A_DUAL_INIT = 8'h00,
  parameter logic [7:0] TRIM_B_DUAL_INIT = 8'h00,
  parameter logic [7:0] TRIM_A_SINA_INIT = 8'h00,
  parameter logic [7:0] TRIM_B_SINA_INIT = 8'h00,
  parameter logic [7:0] TRIM_A_SINB_INIT = 8'h00
) (
  input wire logic i_clk, // 100 MHz register clock
  input wire logic i_rst, // Async reset, active high
  input wire amt_pkg::amt_bus_t i_bus, // Address, data, strobes
  input wire logic [LANES-1:0] i_lane_err, // Lane FIFO over/underflow level
  input wire amt_pkg::amt_alarm_t i_alarm_evt, // Other alarm sources
  input wire logic i_trim_load, // Factory code load pulse
  input wire logic [39:0] i_trim_codes, // Factory codes, A dual lowest
  output logic [7:0] o_rdata, // Read data, cycle after read
  output logic o_summary, // Summary alarm flag
  output logic o_irq, // Level interrupt
  output logic [39:0] o_trims // Applied trim codes
);
  logic [7:0] suppress_reg;
  logic [LANES-1:0] lane_reg;
  logic [5:0] status_reg;
  logic [5:0] irq_mask_reg;
  logic [7:0] trim_reg [5];
  logic [7:0] rdata_reg;
  logic summary_reg;
  logic irq_reg;
  // Factory codes the trims take while reset is held
  localparam logic [39:0] TRIM_INIT = {TRIM_A_SINB_INIT, TRIM_B_SINA_INIT,
    TRIM_A_SINA_INIT, TRIM_B_DUAL_INIT, TRIM_A_DUAL_INIT};

  wire [11:0] addr = i_bus.addr;
  wire wr = i_bus.wr;
  wire [7:0] wd = i_bus.wdata;
  wire sel_sup = addr == `AMT_OFF_SUPPRESS;
  wire sel_lo = addr == `AMT_OFF_LANE_LO;
  wire sel_hi = addr == `AMT_OFF_LANE_HI;
  wire sel_st = addr == `AMT_OFF_STATUS;
  wire sel_im = addr == `AMT_OFF_IRQ_MASK;
  wire [11:0] trim_off [5];
  assign trim_off[0] = `AMT_OFF_TRIM_A_DUAL;
  assign trim_off[1] = `AMT_OFF_TRIM_B_DUAL;
  assign trim_off[2] = `AMT_OFF_TRIM_A_SINA;
  assign trim_off[3] = `AMT_OFF_TRIM_B_SINA;
  assign trim_off[4] = `AMT_OFF_TRIM_A_SINB;

  // Lane write-one-to-clear mask assembled from the two byte addresses
  wire [15:0] lane_w1c16 = {(wr && sel_hi) ? wd : 8'h00,
                            (wr && sel_lo) ? wd : 8'h00};
  wire [LANES-1:0] lane_w1c = lane_w1c16[LANES-1:0];
  wire [LANES-1:0] lane_next = (lane_reg & ~lane_w1c) | i_lane_err;

  // any lane fault drives the FIFO alarm source
  wire [5:0] evt = {i_alarm_evt.fifo | (|i_lane_err),
                    i_alarm_evt.lock_loss, i_alarm_evt.link,
                    i_alarm_evt.realign, i_alarm_evt.oscillator,
                    i_alarm_evt.divider};
  wire [5:0] st_w1c = (wr && sel_st) ? wd[5:0] : 6'h00;
  wire [5:0] status_next = (status_reg & ~st_w1c) | evt;

  // only the six suppress bits gate the summary
  wire [5:0] unsup = status_next & ~suppress_reg[5:0];
  wire summary_next = |unsup;
  wire irq_next = |(status_next & irq_mask_reg);

  logic [7:0] trim_rd;
  always_comb begin
    trim_rd = 8'h00;
    for (int k = 0; k < 5; k++) begin
      if (addr == trim_off[k]) begin
        trim_rd = trim_reg[k];
      end
    end
  end
  wire [15:0] lane16 = 16'(lane_reg);
  wire [7:0] rdata_next =
    !i_bus.rd ? 8'h00 :
    (addr == `AMT_OFF_SUMMARY) ? {7'h00, summary_reg} :
    sel_st ? {2'b00, status_reg} :
    sel_sup ? suppress_reg :
    sel_im ? {2'b00, irq_mask_reg} :
    sel_lo ? lane16[7:0] :
    sel_hi ? lane16[15:8] : trim_rd;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // all alarms suppressed out of reset
      suppress_reg <= `AMT_SUPPRESS_RST;
      // lane faults read one after reset
      lane_reg <= LANES'(`AMT_LANE_RST);
      status_reg <= `AMT_STATUS_RST;
      irq_mask_reg <= `AMT_IRQ_MASK_RST;
      rdata_reg <= 8'h00;
      summary_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      if (wr && sel_sup) begin
        suppress_reg <= wd & `AMT_SUPPRESS_USED;
      end
      if (wr && sel_im) begin
        irq_mask_reg <= wd[5:0];
      end
      lane_reg <= lane_next;
      status_reg <= status_next;
      rdata_reg <= rdata_next;
      summary_reg <= summary_next;
      irq_reg <= irq_next;
    end
  end

  // one code per core and mode
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < 5; k++) begin
        trim_reg[k] <= TRIM_INIT[k*8 +: 8];
      end
    end else if (i_trim_load) begin
      for (int k = 0; k < 5; k++) begin
        trim_reg[k] <= i_trim_codes[k*8 +: 8];
      end
    end else begin
      for (int k = 0; k < 5; k++) begin
        if (wr && addr == trim_off[k]) begin
          trim_reg[k] <= wd;
        end
      end
    end
  end

  // Applied codes lag the registers by one cycle so the outputs are flops
  logic [39:0] trims_reg;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      trims_reg <= 40'h0;
    end else begin
      trims_reg <= {trim_reg[4], trim_reg[3], trim_reg[2], trim_reg[1],
                    trim_reg[0]};
    end
  end

  assign o_rdata = rdata_reg;
  assign o_summary = summary_reg;
  assign o_irq = irq_reg;
  assign o_trims = trims_reg;

  lane_clear_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (wr && sel_lo && wd[0] && !i_lane_err[0]) |=> !lane_reg[0])
    else $error("lane bit not cleared");
  lane_reset_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_lane_err[0] |=> lane_reg[0])
    else $error("persisting lane fault lost");
  lane_keep_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (lane_reg[1] && !(wr && sel_lo && wd[1])) |=> lane_reg[1])
    else $error("lane bit dropped without clear");
  suppress_gate_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (suppress_reg[5:0] == 6'h3f) |=> !summary_reg)
    else $error("suppressed alarm reached summary");
  summary_flag_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $rose(summary_reg) |-> |($past(status_next) & ~$past(suppress_reg[5:0])))
    else $error("summary set without cause");
  fifo_status_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (|i_lane_err) |=> status_reg[`AMT_BIT_FIFO])
    else $error("fifo status missed lane fault");
  reserved_zero_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    suppress_reg[7:6] == 2'b00)
    else $error("reserved suppress bits set");
  trim_write_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (wr && addr == `AMT_OFF_TRIM_B_DUAL && !i_trim_load)
      |=> trim_reg[1] == $past(wd))
    else $error("trim write lost");
  trim_read_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_bus.rd && addr == `AMT_OFF_TRIM_A_DUAL)
      |=> o_rdata == $past(trim_reg[0]))
    else $error("trim readback wrong");

  lane_hi_clear_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (wr && sel_hi && wd[0] && !i_lane_err[8]) |=> !lane_reg[8])
    else $error("lane high byte not cleared");

  lane_top_set_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_lane_err[LANES-1] |=> lane_reg[LANES-1])
    else $error("top lane fault lost");

  lane_zero_keep_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (wr && sel_lo && wd == 8'h00) |=> lane_reg[7:0] == $past(lane_reg[7:0]))
    else $error("zero write changed lane bits");

  lane_idle_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !wr |=> lane_reg == ($past(lane_reg) | $past(i_lane_err)))
    else $error("lane bits changed without write");

  suppress_write_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (wr && sel_sup) |=> suppress_reg == ($past(wd) & 8'h3f))
    else $error("suppress write wrong");

  suppress_hold_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !(wr && sel_sup) |=> $stable(suppress_reg))
    else $error("suppress bits changed without write");

  summary_clear_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    ((status_next & ~suppress_reg[5:0]) == 6'h00) |=> !summary_reg)
    else $error("summary set with all alarms suppressed");

  summary_set_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    ((status_next & ~suppress_reg[5:0]) != 6'h00) |=> summary_reg)
    else $error("summary missed open alarm");

  status_sticky_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (status_reg[5] && !(wr && sel_st && wd[5])) |=> status_reg[5])
    else $error("fifo status dropped without clear");

  status_clear_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (wr && sel_st && wd[5] && !i_alarm_evt.fifo && !(|i_lane_err))
      |=> !status_reg[5])
    else $error("fifo status not cleared");

  reserved_read_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_bus.rd && sel_sup) |=> o_rdata[7:6] == 2'b00)
    else $error("reserved suppress bits read back");

  lane_read_lo_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_bus.rd && sel_lo) |=> o_rdata == $past(lane_reg[7:0]))
    else $error("lane low byte readback wrong");

  lane_read_hi_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_bus.rd && sel_hi) |=> o_rdata == $past(lane_reg[15:8]))
    else $error("lane high byte readback wrong");

  trim_load_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_trim_load |=> trim_reg[4] == $past(i_trim_codes[39:32]))
    else $error("factory code load lost");

  trim_hold_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (!i_trim_load && !wr) |=> $stable(trim_reg[2]))
    else $error("trim code changed without write");

  trim_sina_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (wr && addr == `AMT_OFF_TRIM_B_SINA && !i_trim_load)
      |=> trim_reg[3] == $past(wd))
    else $error("single mode trim write lost");

  trim_apply_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    1'b1 |=> o_trims[15:8] == $past(trim_reg[1]))
    else $error("applied trim code wrong");
endmodule

// ===== amt_regs.svh
`ifndef AMT_REGS_SVH
`define AMT_REGS_SVH

`define AMT_OFF_SUPPRESS 12'h2c2
`define AMT_OFF_LANE_LO 12'h2c4
`define AMT_OFF_LANE_HI 12'h2c5
`define AMT_OFF_TRIM_A_DUAL 12'h310
`define AMT_OFF_TRIM_B_DUAL 12'h313
`define AMT_OFF_TRIM_A_SINA 12'h314
`define AMT_OFF_TRIM_B_SINA 12'h315
`define AMT_OFF_TRIM_A_SINB 12'h31a
`define AMT_OFF_SUMMARY 12'h2c0
`define AMT_OFF_STATUS 12'h2c1
`define AMT_OFF_IRQ_MASK 12'h2c3

`define AMT_SUPPRESS_RST 8'h3f
`define AMT_SUPPRESS_USED 8'h3f
`define AMT_LANE_RST 16'hffff
`define AMT_STATUS_RST 6'h3f
`define AMT_IRQ_MASK_RST 6'h00
`define AMT_BIT_FIFO 5

`endif

// ===== amt_regs_tb.sv
`timescale 1ns/1ps
`include "amt_regs.svh"

module amt_regs_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  amt_pkg::amt_bus_t i_bus = '0;
  logic [15:0] i_lane_err = 16'h0000;
  amt_pkg::amt_alarm_t i_alarm_evt = '0;
  logic i_trim_load = 1'b0;
  logic [39:0] i_trim_codes = 40'h0;
  logic [7:0] o_rdata;
  logic o_summary;
  logic o_irq;
  logic [39:0] o_trims;
  int bad_count = 0;
  int total_checks = 0;
  logic [11:0] ta [5] = '{`AMT_OFF_TRIM_A_DUAL, `AMT_OFF_TRIM_B_DUAL,
    `AMT_OFF_TRIM_A_SINA, `AMT_OFF_TRIM_B_SINA, `AMT_OFF_TRIM_A_SINB};

  always #5 i_clk = ~i_clk;

  amt_regs dut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_bus(i_bus),
    .i_lane_err(i_lane_err),
    .i_alarm_evt(i_alarm_evt),
    .i_trim_load(i_trim_load),
    .i_trim_codes(i_trim_codes),
    .o_rdata(o_rdata),
    .o_summary(o_summary),
    .o_irq(o_irq),
    .o_trims(o_trims)
  );

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    i_bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [11:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    i_bus.rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  task automatic t_reset();
    rc(`AMT_OFF_SUPPRESS, 8'h3f);
    rc(`AMT_OFF_LANE_LO, 8'hff);
    rc(`AMT_OFF_LANE_HI, 8'hff);
    for (int i = 0; i < 5; i++) rc(ta[i], 8'h00);
    chk(o_summary, 1'b0);
  endtask

  task automatic t_suppress();
    wr(`AMT_OFF_SUPPRESS, 8'hff);
    rc(`AMT_OFF_SUPPRESS, 8'h3f);
    // Status is all ones after reset, so any open bit raises the flag
    for (int b = 0; b < 6; b++) begin
      wr(`AMT_OFF_SUPPRESS, 8'h3f & ~(8'h01 << b));
      settle();
      chk(o_summary, 1'b1);
    end
    wr(`AMT_OFF_SUPPRESS, 8'hff);
    settle();
    chk(o_summary, 1'b0);
    wr(`AMT_OFF_STATUS, 8'h3f);
    wr(`AMT_OFF_SUPPRESS, 8'h00);
    settle();
    chk(o_summary, 1'b0);
    @(posedge i_clk);
    i_alarm_evt <= 6'h08;
    @(posedge i_clk);
    i_alarm_evt <= 6'h00;
    settle();
    chk(o_summary, 1'b1);
    rc(`AMT_OFF_STATUS, 8'h08);
  endtask

  task automatic t_irq();
    wr(`AMT_OFF_IRQ_MASK, 8'h08);
    settle();
    chk(o_irq, 1'b1);
    wr(`AMT_OFF_STATUS, 8'h08);
    settle();
    chk({o_irq, o_summary}, 2'b00);
  endtask

  task automatic t_lane();
    wr(`AMT_OFF_LANE_LO, 8'h01);
    rc(`AMT_OFF_LANE_LO, 8'hfe);
    wr(`AMT_OFF_LANE_LO, 8'h00);
    rc(`AMT_OFF_LANE_LO, 8'hfe);
    @(posedge i_clk);
    i_lane_err <= 16'h0100;
    wr(`AMT_OFF_LANE_HI, 8'hff);
    rc(`AMT_OFF_LANE_HI, 8'h01);
    rc(`AMT_OFF_STATUS, 8'h20);
    chk(o_summary, 1'b1);
    @(posedge i_clk);
    i_lane_err <= 16'h0000;
    wr(`AMT_OFF_LANE_HI, 8'hff);
    rc(`AMT_OFF_LANE_HI, 8'h00);
  endtask

  task automatic t_trim();
    for (int i = 0; i < 5; i++) wr(ta[i], 8'h31 + 8'h11 * i[7:0]);
    wr(12'h311, 8'hff);
    rc(12'h311, 8'h00);
    for (int i = 0; i < 5; i++) rc(ta[i], 8'h31 + 8'h11 * i[7:0]);
    chk(o_trims, 40'h7564534231);
    @(posedge i_clk);
    i_trim_codes <= 40'h5a4b3c2d1e;
    i_trim_load <= 1'b1;
    @(posedge i_clk);
    i_trim_load <= 1'b0;
    rc(ta[0], 8'h1e);
    rc(ta[4], 8'h5a);
    chk(o_trims, 40'h5a4b3c2d1e);
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_suppress();
    t_irq();
    t_lane();
    t_trim();
    print_verdict();
  end
endmodule
